// file: common/otfs_consts.svh
// How it works
// - Open-collector output drives the function chosen by its selector, default code 01.
// - Analog monitor carries speed at 00, current at 01, default 00.
// - Open-collector polarity 00 is normally open, 01 normally closed, default 00.
// - Relay polarity 00 normally open, 01 normally closed, default 01.
// - Code 00 asserts in run mode, deasserts in stop mode.
// - Code 01 asserts only when output equals set frequency, not ramping.
// - Code 02 asserts when output is on and output frequency is at or above set frequency.
// - Code 03 asserts while current exceeds the overload warning threshold.
// - Code 04 asserts while PID error exceeds the deviation threshold.
// - Safe-stop input function is never assignable by software, only by the switch.
// - Switch on: terminal 3 safe stop (NC), 4 reset (NO), 5 unused.
// - After switch on to off: terminals 3 and 5 unused, 4 reset, 1/2 run.
// - Code 05 asserts while an uncleared alarm exists.
`ifndef OTFS_CONSTS_SVH
`define OTFS_CONSTS_SVH

`define OTFS_ADDR_OUT11_FUNC   8'h00
`define OTFS_ADDR_RELAY_FUNC   8'h04
`define OTFS_ADDR_ANALOG_SEL   8'h08
`define OTFS_ADDR_OUT11_POL    8'h0c
`define OTFS_ADDR_RELAY_POL    8'h10
`define OTFS_ADDR_STATUS       8'h14
`define OTFS_ADDR_OVL_THRESH   8'h18
`define OTFS_ADDR_DEV_THRESH   8'h1c

`define OTFS_RST_OUT11_FUNC    8'h01
`define OTFS_RST_RELAY_FUNC    8'h05
`define OTFS_RST_ANALOG_SEL    8'h00
`define OTFS_RST_OUT11_POL     8'h00
`define OTFS_RST_RELAY_POL     8'h01
`define OTFS_RST_OVL_THRESH    16'hffff
`define OTFS_RST_DEV_THRESH    16'hffff

`define OTFS_POL_NC_BIT        0
`define OTFS_ANA_CURRENT_BIT   0

`endif

// file: common/otfs_pkg.sv
package otfs_pkg;
    typedef enum logic [7:0] {
        OTFS_FN_RUN       = 8'h00,
        OTFS_FN_ARR_CONST = 8'h01,
        OTFS_FN_ARR_OVER  = 8'h02,
        OTFS_FN_OVERLOAD  = 8'h03,
        OTFS_FN_PID_DEV   = 8'h04,
        OTFS_FN_FAULT     = 8'h05
    } otfs_func_t;

    typedef enum logic [1:0] {
        OTFS_T_DEFAULT  = 2'b00,
        OTFS_T_SWITCHED = 2'b01,
        OTFS_T_RELEASED = 2'b10
    } otfs_term_mode_t;
endpackage

// file: rtl/otfs_output_select.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "otfs_consts.svh"

module otfs_output_select (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      run_mode,
    input  wire logic                      output_on,
    input  wire logic                      ramping,
    input  wire logic [15:0]               out_freq,
    input  wire logic [15:0]               set_freq,
    input  wire logic [15:0]               out_current,
    input  wire logic [15:0]               pid_error,
    input  wire logic                      alarm_event,
    input  wire logic                      alarm_clear,
    input  wire logic                      stop_switch,
    input  wire logic [4:0]                term_pins,
    output logic                           out11_pin,
    output logic                           relay_pin,
    output logic [15:0]                    analog_monitor_pin,
    output logic                           forward_run_input,
    output logic                           reverse_run_input,
    output logic                           speed_select_bit0,
    output logic                           speed_select_bit1,
    output logic                           reset_input,
    output logic                           safe_stop_input,
    output otfs_pkg::otfs_term_mode_t      term_mode
);
    import otfs_pkg::*;

    logic [7:0]  out11_func_sel_reg;
    logic [7:0]  relay_func_sel_reg;
    logic [7:0]  analog_mon_sel_reg;
    logic [7:0]  out11_polarity_reg;
    logic [7:0]  relay_polarity_sel_reg;
    logic [15:0] ovl_thresh_reg;
    logic [15:0] dev_thresh_reg;
    logic        fault_reg;

    // Write channel: address and data latched independently
    logic        aw_held_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        do_write;
    logic        write_ok;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // Settings refused in run mode answer SLVERR; thresholds stay writable
    logic locked_addr;
    logic known_waddr;
    always_comb begin
        locked_addr = 1'b0;
        known_waddr = 1'b1;
        if (aw_addr_reg[1:0] != 2'b00 || aw_addr_reg > `OTFS_ADDR_DEV_THRESH
            || aw_addr_reg == `OTFS_ADDR_STATUS) begin
            known_waddr = 1'b0;
        end else if (aw_addr_reg <= `OTFS_ADDR_RELAY_POL) begin
            locked_addr = 1'b1;
        end
    end
    assign write_ok = known_waddr && !(locked_addr && run_mode);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wen;
    assign wen = do_write && write_ok && w_strb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out11_func_sel_reg     <= `OTFS_RST_OUT11_FUNC;
            relay_func_sel_reg     <= `OTFS_RST_RELAY_FUNC;
            analog_mon_sel_reg     <= `OTFS_RST_ANALOG_SEL;
            out11_polarity_reg     <= `OTFS_RST_OUT11_POL;
            relay_polarity_sel_reg <= `OTFS_RST_RELAY_POL;
        end else if (wen) begin
            if (aw_addr_reg == `OTFS_ADDR_OUT11_FUNC) begin
                out11_func_sel_reg <= w_data_reg[7:0];
            end else if (aw_addr_reg == `OTFS_ADDR_RELAY_FUNC) begin
                relay_func_sel_reg <= w_data_reg[7:0];
            end else if (aw_addr_reg == `OTFS_ADDR_ANALOG_SEL) begin
                analog_mon_sel_reg <= w_data_reg[7:0];
            end else if (aw_addr_reg == `OTFS_ADDR_OUT11_POL) begin
                out11_polarity_reg <= w_data_reg[7:0];
            end else if (aw_addr_reg == `OTFS_ADDR_RELAY_POL) begin
                relay_polarity_sel_reg <= w_data_reg[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovl_thresh_reg <= `OTFS_RST_OVL_THRESH;
            dev_thresh_reg <= `OTFS_RST_DEV_THRESH;
        end else if (do_write && write_ok) begin
            if (aw_addr_reg == `OTFS_ADDR_OVL_THRESH) begin
                if (w_strb_reg[0]) ovl_thresh_reg[7:0]  <= w_data_reg[7:0];
                if (w_strb_reg[1]) ovl_thresh_reg[15:8] <= w_data_reg[15:8];
            end else if (aw_addr_reg == `OTFS_ADDR_DEV_THRESH) begin
                if (w_strb_reg[0]) dev_thresh_reg[7:0]  <= w_data_reg[7:0];
                if (w_strb_reg[1]) dev_thresh_reg[15:8] <= w_data_reg[15:8];
            end
        end
    end

    // Alarm latch: a new event wins over a simultaneous clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_reg <= 1'b0;
        end else if (alarm_event) begin
            fault_reg <= 1'b1;
        end else if (alarm_clear) begin
            fault_reg <= 1'b0;
        end
    end

    // Status functions
    logic freq_arrival_const;
    logic freq_arrival_over;
    logic overload_warning;
    logic pid_deviation_flag;
    assign freq_arrival_const = output_on && !ramping && (out_freq == set_freq);
    assign freq_arrival_over  = output_on && (out_freq >= set_freq);
    assign overload_warning   = out_current > ovl_thresh_reg;
    assign pid_deviation_flag = pid_error > dev_thresh_reg;

    function automatic logic func_result(input logic [7:0] sel, input logic flt);
        logic r;
        r = 1'b0;
        case (sel)
            OTFS_FN_RUN:       r = run_mode;
            OTFS_FN_ARR_CONST: r = freq_arrival_const;
            OTFS_FN_ARR_OVER:  r = freq_arrival_over;
            OTFS_FN_OVERLOAD:  r = overload_warning;
            OTFS_FN_PID_DEV:   r = pid_deviation_flag;
            OTFS_FN_FAULT:     r = flt;
            default:           r = 1'b0;
        endcase
        return r;
    endfunction

    // Normally open: out11 drives low when active, relay drives high; normally closed inverts each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out11_pin <= 1'b1;
            relay_pin <= 1'b0;
        end else begin
            out11_pin <= !func_result(out11_func_sel_reg, fault_reg)
                         ^ out11_polarity_reg[`OTFS_POL_NC_BIT];
            relay_pin <= func_result(relay_func_sel_reg, fault_reg)
                         ^ relay_polarity_sel_reg[`OTFS_POL_NC_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_monitor_pin <= 16'h0000;
        end else if (analog_mon_sel_reg[`OTFS_ANA_CURRENT_BIT]) begin
            analog_monitor_pin <= out_current;
        end else begin
            analog_monitor_pin <= out_freq;
        end
    end

    // Pins and switch (bit 5): three stages, a change counts when two and three agree
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic [5:0] pin_s3_reg;
    logic [5:0] pin_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg <= 6'h00;
            pin_s2_reg <= 6'h00;
            pin_s3_reg <= 6'h00;
        end else begin
            pin_s1_reg <= {stop_switch, term_pins};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_reg[gi] <= 1'b0;
                end else if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
                    pin_reg[gi] <= pin_s3_reg[gi];
                end
            end
        end
    endgenerate

    // Only the hardware switch moves terminal mapping; no register reaches it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_mode <= OTFS_T_DEFAULT;
        end else if (pin_reg[5]) begin
            term_mode <= OTFS_T_SWITCHED;
        end else if (term_mode == OTFS_T_SWITCHED) begin
            term_mode <= OTFS_T_RELEASED;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            forward_run_input <= 1'b0;
            reverse_run_input <= 1'b0;
            speed_select_bit0 <= 1'b0;
            speed_select_bit1 <= 1'b0;
            reset_input       <= 1'b0;
            safe_stop_input   <= 1'b0;
        end else begin
            forward_run_input <= pin_reg[0];
            reverse_run_input <= pin_reg[1];
            case (term_mode)
                OTFS_T_SWITCHED: begin
                    speed_select_bit0 <= 1'b0;
                    speed_select_bit1 <= 1'b0;
                    safe_stop_input   <= !pin_reg[2];
                    reset_input       <= pin_reg[3];
                end
                OTFS_T_RELEASED: begin
                    speed_select_bit0 <= 1'b0;
                    speed_select_bit1 <= 1'b0;
                    safe_stop_input   <= 1'b0;
                    reset_input       <= pin_reg[3];
                end
                default: begin
                    speed_select_bit0 <= pin_reg[2];
                    speed_select_bit1 <= pin_reg[3];
                    safe_stop_input   <= 1'b0;
                    reset_input       <= pin_reg[4];
                end
            endcase
        end
    end

    // Read channel
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == `OTFS_ADDR_OUT11_FUNC) begin
            rd_word = {24'h000000, out11_func_sel_reg};
        end else if (s_axi_araddr == `OTFS_ADDR_RELAY_FUNC) begin
            rd_word = {24'h000000, relay_func_sel_reg};
        end else if (s_axi_araddr == `OTFS_ADDR_ANALOG_SEL) begin
            rd_word = {24'h000000, analog_mon_sel_reg};
        end else if (s_axi_araddr == `OTFS_ADDR_OUT11_POL) begin
            rd_word = {24'h000000, out11_polarity_reg};
        end else if (s_axi_araddr == `OTFS_ADDR_RELAY_POL) begin
            rd_word = {24'h000000, relay_polarity_sel_reg};
        end else if (s_axi_araddr == `OTFS_ADDR_STATUS) begin
            rd_word = {22'h000000, term_mode, relay_pin, out11_pin, pid_deviation_flag,
                       overload_warning, freq_arrival_over, freq_arrival_const,
                       fault_reg, run_mode};
        end else if (s_axi_araddr == `OTFS_ADDR_OVL_THRESH) begin
            rd_word = {16'h0000, ovl_thresh_reg};
        end else if (s_axi_araddr == `OTFS_ADDR_DEV_THRESH) begin
            rd_word = {16'h0000, dev_thresh_reg};
        end
    end

    logic rd_known;
    assign rd_known = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `OTFS_ADDR_DEV_THRESH);
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_known ? rd_word : 32'h0000_0000;
            s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// file: verification/otfs_output_select_properties.sv
`timescale 1ns/1ps
module otfs_output_select_checker (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic [7:0]           s_axi_awaddr,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 run_mode,
    input wire logic [15:0]          out_freq,
    input wire logic [15:0]          out_current,
    input wire logic                 stop_switch,
    input wire logic [4:0]           term_pins,
    input wire logic                 out11_pin,
    input wire logic                 relay_pin,
    input wire logic [15:0]          analog_monitor_pin,
    input wire logic                 forward_run_input,
    input wire logic                 reverse_run_input,
    input wire logic                 speed_select_bit0,
    input wire logic                 speed_select_bit1,
    input wire logic                 reset_input,
    input wire logic                 safe_stop_input,
    input wire otfs_pkg::otfs_term_mode_t term_mode
);
    import otfs_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_run_write_err: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && run_mode
        && s_axi_awaddr <= 8'h10 |-> ##2 s_axi_bvalid && s_axi_bresp == 2'b10)
        else $error("settings write in run mode not refused");
    a_resp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_reset_levels: assert property (
        disable iff (1'b0) !aresetn |=> out11_pin && !relay_pin && term_mode == OTFS_T_DEFAULT)
        else $error("outputs not at rest after reset");
    a_analog_route: assert property (
        1'b1 |=> analog_monitor_pin == $past(out_freq) || analog_monitor_pin == $past(out_current))
        else $error("analog monitor carries neither speed nor current");
    a_fixed_terms: assert property (
        ($stable(term_pins) && $stable(stop_switch)) [*8] |->
        forward_run_input == term_pins[0] && reverse_run_input == term_pins[1])
        else $error("run terminals not decoded");
    a_switch_terms: assert property (
        (stop_switch && $stable(stop_switch) && $stable(term_pins)) [*8] |->
        safe_stop_input == !term_pins[2] && reset_input == term_pins[3]
        && !speed_select_bit0 && !speed_select_bit1)
        else $error("switched terminal map wrong");
    a_no_soft_stop: assert property (
        (!stop_switch && $stable(stop_switch)) [*8] |-> !safe_stop_input)
        else $error("safe stop active without switch");
    a_release_terms: assert property (
        (term_mode == OTFS_T_RELEASED && $stable(term_pins)) [*8] |->
        !speed_select_bit0 && !speed_select_bit1 && reset_input == term_pins[3])
        else $error("released terminal map wrong");

    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property ($rose(safe_stop_input));
    cover property (term_mode == OTFS_T_RELEASED ##1 reset_input);
endmodule

bind otfs_output_select otfs_output_select_checker u_otfs_output_select_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .run_mode(run_mode),
    .out_freq(out_freq), .out_current(out_current), .stop_switch(stop_switch),
    .term_pins(term_pins), .out11_pin(out11_pin), .relay_pin(relay_pin),
    .analog_monitor_pin(analog_monitor_pin), .forward_run_input(forward_run_input),
    .reverse_run_input(reverse_run_input), .speed_select_bit0(speed_select_bit0),
    .speed_select_bit1(speed_select_bit1), .reset_input(reset_input),
    .safe_stop_input(safe_stop_input), .term_mode(term_mode));

// file: verification/otfs_field_model.sv
`timescale 1ns/1ps
module otfs_field_model #(
    parameter int SETTLE_NS = 2
) (
    input wire logic [4:0] contact_cmd,
    input wire logic       switch_cmd,
    output logic [4:0]     term_pins,
    output logic           stop_switch
);
    // Contacts land off the clock grid, as field wiring does
    initial term_pins = 5'h00;
    initial stop_switch = 1'b0;
    always @(contact_cmd) term_pins <= #(SETTLE_NS) contact_cmd;
    always @(switch_cmd) stop_switch <= #(SETTLE_NS) switch_cmd;
endmodule

// file: verification/output_terminal_function_select_bench.sv
`timescale 1ns/1ps
module output_terminal_function_select_bench;
    import otfs_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run_mode = 1'b0;
    logic output_on = 1'b0, ramping = 1'b0, alarm_event = 1'b0, alarm_clear = 1'b0;
    logic switch_cmd = 1'b0, stop_switch, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, out11_pin, relay_pin, forward_run_input;
    logic reverse_run_input, reset_input, speed_select_bit0, speed_select_bit1, safe_stop_input;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [15:0] out_freq = 16'h0, set_freq = 16'h0, out_current = 16'h0, pid_error = 16'h0;
    logic [15:0] analog_monitor_pin;
    logic [4:0] contact_cmd = 5'h00, term_pins;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [77:0] rows [12];
    otfs_term_mode_t term_mode;
    int bad_count = 0, checks_done = 0, i;

    always #2.5 aclk = ~aclk;

    otfs_output_select u_otfs_output_select (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .run_mode(run_mode),
        .output_on(output_on), .ramping(ramping), .out_freq(out_freq), .set_freq(set_freq),
        .out_current(out_current), .pid_error(pid_error), .alarm_event(alarm_event),
        .alarm_clear(alarm_clear), .stop_switch(stop_switch), .term_pins(term_pins),
        .out11_pin(out11_pin), .relay_pin(relay_pin), .analog_monitor_pin(analog_monitor_pin),
        .forward_run_input(forward_run_input), .reverse_run_input(reverse_run_input),
        .speed_select_bit0(speed_select_bit0), .speed_select_bit1(speed_select_bit1),
        .reset_input(reset_input), .safe_stop_input(safe_stop_input), .term_mode(term_mode));

    otfs_field_model u_otfs_field_model (.contact_cmd(contact_cmd), .switch_cmd(switch_cmd),
        .term_pins(term_pins), .stop_switch(stop_switch));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Waits for the answer; only the watchdog ends a hang
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic cfg(input logic [7:0] fn, input logic op, input logic rp);
        run_mode <= 1'b0;
        axi_write(8'h00, {24'h0, fn}, resp);
        axi_write(8'h04, {24'h0, fn}, resp);
        axi_write(8'h0c, {31'h0, op}, resp);
        axi_write(8'h10, {31'h0, rp}, resp);
    endtask

    // Open collector is low when active unless normally closed
    task automatic pins_ok(input logic f, input logic op, input logic rp);
        repeat (3) @(posedge aclk);
        check("out11_pin", out11_pin, op ? f : !f);
        check("relay_pin", relay_pin, f ^ rp);
    endtask

    task automatic terms(input logic [4:0] c, input logic sw, input logic [6:0] exp);
        contact_cmd <= c;
        switch_cmd <= sw;
        repeat (12) @(posedge aclk);
        check("terminals", {forward_run_input, reverse_run_input, speed_select_bit0,
            speed_select_bit1, reset_input, safe_stop_input, term_mode == OTFS_T_RELEASED}, exp);
    endtask

    initial begin
        // fn, polarity out11/relay, run on ramp, out_freq set_freq current pid, result
        rows[0] = {8'h00, 5'b01110, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1};
        rows[1] = {8'h00, 5'b10010, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0};
        rows[2] = {8'h01, 5'b01010, 16'h0100, 16'h0100, 16'h0, 16'h0, 1'b1};
        rows[3] = {8'h01, 5'b11011, 16'h0100, 16'h0100, 16'h0, 16'h0, 1'b0};
        rows[4] = {8'h01, 5'b00000, 16'h0100, 16'h0100, 16'h0, 16'h0, 1'b0};
        rows[5] = {8'h02, 5'b00011, 16'h0101, 16'h0100, 16'h0, 16'h0, 1'b1};
        rows[6] = {8'h02, 5'b10010, 16'h00ff, 16'h0100, 16'h0, 16'h0, 1'b0};
        rows[7] = {8'h02, 5'b01000, 16'h0100, 16'h0100, 16'h0, 16'h0, 1'b0};
        rows[8] = {8'h03, 5'b10010, 16'h0, 16'h0, 16'h0101, 16'h0, 1'b1};
        rows[9] = {8'h03, 5'b01010, 16'h0, 16'h0, 16'h0100, 16'h0, 1'b0};
        rows[10] = {8'h04, 5'b00010, 16'h0, 16'h0, 16'h0, 16'h0081, 1'b1};
        rows[11] = {8'h04, 5'b11010, 16'h0, 16'h0, 16'h0, 16'h0080, 1'b0};
        repeat (5) @(posedge aclk);
        check("reset pins", {out11_pin, relay_pin}, 2'b10);
        aresetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            axi_read(8'(i * 4), rd, resp);
            check("reset value", rd, (40'h0105000001 >> (32 - i * 8)) & 32'hff);
        end
        $display("test reset done");
        axi_write(8'h18, 32'h0100, resp);
        axi_write(8'h1c, 32'h0080, resp);
        for (i = 0; i < 12; i++) begin
            cfg(rows[i][77:70], rows[i][69], rows[i][68]);
            run_mode <= rows[i][67];
            output_on <= rows[i][66];
            ramping <= rows[i][65];
            {out_freq, set_freq, out_current, pid_error} <= rows[i][64:1];
            pins_ok(rows[i][0], rows[i][69], rows[i][68]);
        end
        $display("test functions done");
        cfg(8'h05, 1'b1, 1'b0);
        alarm_event <= 1'b1;
        @(posedge aclk);
        alarm_event <= 1'b0;
        repeat (6) @(posedge aclk);
        pins_ok(1'b1, 1'b1, 1'b0);
        alarm_clear <= 1'b1;
        @(posedge aclk);
        alarm_clear <= 1'b0;
        pins_ok(1'b0, 1'b1, 1'b0);
        $display("test alarm done");
        run_mode <= 1'b1;
        axi_write(8'h00, 32'h03, resp);
        check("run write resp", resp, 2'b10);
        axi_read(8'h00, rd, resp);
        check("run write kept", rd, 32'h05);
        axi_read(8'h20, rd, resp);
        check("unmapped read", {rd, resp}, 34'h2);
        axi_write(8'h24, 32'h1, resp);
        check("unmapped write", resp, 2'b10);
        $display("test refusals done");
        run_mode <= 1'b0;
        out_freq <= 16'h0555;
        out_current <= 16'h1234;
        axi_write(8'h08, 32'h1, resp);
        repeat (3) @(posedge aclk);
        check("analog current", analog_monitor_pin, 16'h1234);
        axi_write(8'h08, 32'h0, resp);
        repeat (3) @(posedge aclk);
        check("analog speed", analog_monitor_pin, 16'h0555);
        $display("test analog done");
        terms(5'h1f, 1'b0, 7'b1111100);
        terms(5'h1b, 1'b1, 7'b1100110);
        terms(5'h17, 1'b0, 7'b1100001);
        terms(5'h08, 1'b0, 7'b0000101);
        $display("test terminals done");
        wrap_up();
    end

    initial begin
        #300000;
        bad_count++;
        wrap_up();
    end
endmodule
